// ---- rtl/scbp_regs.svh ----
`ifndef SCBP_REGS_SVH
`define SCBP_REGS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SCBP_CLK_PERIOD_NS 20
`define SCBP_T_RAS_NS 42
`define SCBP_T_RAS_CYC \
   ((`SCBP_T_RAS_NS + `SCBP_CLK_PERIOD_NS - 1) / `SCBP_CLK_PERIOD_NS)
`define SCBP_T_WR_CYC 2

// ----------------------------------------
// Mode encodings
// ----------------------------------------
`define SCBP_BL1 3'h0
`define SCBP_BL2 3'h1
`define SCBP_BL4 3'h2
`define SCBP_BL8 3'h3
`define SCBP_BL_PAGE 3'h7
`define SCBP_CL3 2'h3

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SCBP_AP_BIT 10
`define SCBP_BANK_RST 4'h0

`endif

// ---- rtl/scbp_pkg.sv ----
package scbp_pkg;

   typedef logic [8:0] scbp_col_t;
   typedef logic [12:0] scbp_row_t;
   typedef logic [1:0] scbp_bank_t;
   typedef logic [15:0] scbp_data_t;

   typedef enum logic [1:0]
   {
      SCBP_IDLE,
      SCBP_READ,
      SCBP_WRITE
   } scbp_state_e;

endpackage : scbp_pkg

// ---- rtl/scbp_col_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scbp_regs.svh"

module scbp_col_gen (
   // Burst position
   input wire scbp_pkg::scbp_col_t base,
   input wire scbp_pkg::scbp_col_t idx,
   // Mode
   input wire logic [2:0] len_code,
   input wire logic interleave,
   // Result
   output scbp_pkg::scbp_col_t col,
   output logic last
);
   import scbp_pkg::*;

   scbp_col_t mask;
   scbp_col_t sum;

   always_comb
   begin
      unique case (len_code)
         `SCBP_BL1: mask = 9'h000;
         `SCBP_BL2: mask = 9'h001;
         `SCBP_BL4: mask = 9'h003;
         `SCBP_BL8: mask = 9'h007;
         `SCBP_BL_PAGE: mask = 9'h1FF;
         // Reserved codes behave as single word
         default: mask = 9'h000;
      endcase
   end

   assign sum = 9'(base + idx);

   always_comb
   begin
      // Page bursts always count up; interleave has no page form
      if (interleave && len_code != `SCBP_BL_PAGE)
         col = base ^ (idx & mask);
      else
         col = (base & ~mask) | (sum & mask);
   end

   // Page bursts never end by themselves
   assign last = (idx == mask) && (len_code != `SCBP_BL_PAGE);

endmodule // scbp_col_gen

`default_nettype wire

// ---- rtl/scbp_column_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scbp_regs.svh"


module scbp_column_engine (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Command pins
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire scbp_pkg::scbp_bank_t bank_select,
   input wire scbp_pkg::scbp_row_t addr,
   input wire logic [1:0] dqm,
   // Data pins
   input wire scbp_pkg::scbp_data_t dq_in,
   output scbp_pkg::scbp_data_t dq_out,
   output logic [1:0] dq_oe,
   // Mode settings
   input wire logic [2:0] mode_burst_len,
   input wire logic mode_interleave,
   input wire logic [1:0] mode_cas_lat,
   // Array port
   output logic mem_rd_en,
   output logic mem_wr_en,
   output scbp_pkg::scbp_bank_t mem_bank,
   output scbp_pkg::scbp_row_t mem_row,
   output scbp_pkg::scbp_col_t mem_col,
   output scbp_pkg::scbp_data_t mem_wdata,
   output logic [1:0] mem_wbe,
   input wire scbp_pkg::scbp_data_t mem_rdata,
   // Status
   output logic [3:0] bank_active,
   output logic illegal_cmd
);
   import scbp_pkg::*;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   logic cmd_act;
   logic cmd_rd;
   logic cmd_wr;
   logic cmd_pre;
   logic cmd_bst;
   logic col_ok;
   logic rd_go;
   logic wr_go;
   logic new_cmd;
   logic full_page;
   logic bst_go;
   logic cl3;
   logic [3:0] bank_active_q;

   assign cmd_act = !cs_n && !ras_n && cas_n && we_n;
   assign cmd_rd = !cs_n && ras_n && !cas_n && we_n;
   assign cmd_wr = !cs_n && ras_n && !cas_n && !we_n;
   assign cmd_pre = !cs_n && !ras_n && cas_n && !we_n;
   assign cmd_bst = !cs_n && ras_n && cas_n && !we_n;
   assign col_ok = bank_active_q[bank_select];
   assign rd_go = cmd_rd && col_ok;
   assign wr_go = cmd_wr && col_ok;
   assign new_cmd = rd_go || wr_go;
   assign full_page = (mode_burst_len == `SCBP_BL_PAGE);
   assign bst_go = cmd_bst && full_page;
   assign cl3 = (mode_cas_lat == `SCBP_CL3);

   // ----------------------------------------
   // Burst sequencer
   // ----------------------------------------
   scbp_state_e state_q;
   scbp_col_t cnt_q;
   scbp_col_t base_q;
   scbp_bank_t bank_q;
   logic ap_q;
   scbp_col_t gen_base;
   scbp_col_t gen_idx;
   scbp_col_t gen_col;
   logic gen_last;
   logic pre_hit;
   logic cont_ok;
   logic rd_issue;
   logic wr_issue;
   logic cont;
   scbp_bank_t issue_bank;
   logic burst_end_ap;
   logic end_is_rd;

   // A precharge to the bursting bank cuts the burst
   assign pre_hit = cmd_pre && (addr[`SCBP_AP_BIT] || bank_select == bank_q);
   assign cont_ok = !new_cmd && !bst_go && !pre_hit;
   assign rd_issue = rd_go || (state_q == SCBP_READ && cont_ok);
   assign wr_issue = wr_go || (state_q == SCBP_WRITE && cont_ok);
   assign cont = (state_q != SCBP_IDLE) && cont_ok;
   assign issue_bank = new_cmd ? bank_select : bank_q;
   assign gen_base = new_cmd ? addr[8:0] : base_q;
   assign gen_idx = new_cmd ? 9'h000 : cnt_q;
   assign end_is_rd = new_cmd ? rd_go : (state_q == SCBP_READ);
   assign burst_end_ap = gen_last &&
      ((new_cmd && addr[`SCBP_AP_BIT]) || (cont && ap_q));

   scbp_col_gen u_col_gen (
      .base(gen_base),
      .idx(gen_idx),
      .len_code(mode_burst_len),
      .interleave(mode_interleave),
      .col(gen_col),
      .last(gen_last)
   );

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_q <= SCBP_IDLE;
         cnt_q <= 9'h000;
         base_q <= 9'h000;
         bank_q <= 2'h0;
         ap_q <= 1'b0;
      end
      else if (new_cmd)
      begin
         // Interrupting command drops what is left of the old burst
         base_q <= addr[8:0];
         bank_q <= bank_select;
         ap_q <= addr[`SCBP_AP_BIT] && !full_page;
         cnt_q <= 9'h001;
         if (gen_last)
            state_q <= SCBP_IDLE;
         else if (rd_go)
            state_q <= SCBP_READ;
         else
            state_q <= SCBP_WRITE;
      end
      else if (cont)
      begin
         cnt_q <= 9'(cnt_q + 9'h001);
         if (gen_last)
            state_q <= SCBP_IDLE;
      end
      else
      begin
         state_q <= SCBP_IDLE;
      end
   end

   // ----------------------------------------
   // Auto precharge
   // ----------------------------------------
   logic ap_pend_q;
   logic [1:0] ap_cnt_q;
   scbp_bank_t ap_bank_q;
   logic [3:0] ras_ok;
   logic ap_fire;

   assign ap_fire = ap_pend_q && ap_cnt_q == 2'h1 &&
      ras_ok[ap_bank_q];

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         ap_pend_q <= 1'b0;
         ap_cnt_q <= 2'h0;
         ap_bank_q <= 2'h0;
      end
      else if (burst_end_ap)
      begin
         ap_pend_q <= 1'b1;
         ap_bank_q <= issue_bank;
         // Reads close right after the last address, writes wait tWR
         ap_cnt_q <= end_is_rd ? 2'h1 : 2'(`SCBP_T_WR_CYC);
      end
      else if (ap_pend_q)
      begin
         if (ap_cnt_q > 2'h1)
            ap_cnt_q <= ap_cnt_q - 2'h1;
         else if (ap_fire)
            ap_pend_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Bank tracking
   // ----------------------------------------
   scbp_row_t row_q [4];
   logic [3:0] ras_cnt_q [4];

   always_comb
   begin
      for (int b = 0; b < 4; b++)
         ras_ok[b] = (ras_cnt_q[b] >= 4'(`SCBP_T_RAS_CYC));
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         bank_active_q <= `SCBP_BANK_RST;
         for (int b = 0; b < 4; b++)
         begin
            row_q[b] <= 13'h0000;
            ras_cnt_q[b] <= 4'h0;
         end
      end
      else
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (cmd_act && bank_select == 2'(b) && !bank_active_q[b])
            begin
               bank_active_q[b] <= 1'b1;
               row_q[b] <= addr;
               ras_cnt_q[b] <= 4'h0;
            end
            else if ((cmd_pre && (addr[`SCBP_AP_BIT] ||
               bank_select == 2'(b))) ||
               (ap_fire && ap_bank_q == 2'(b)))
            begin
               bank_active_q[b] <= 1'b0;
            end
            else if (bank_active_q[b] && !ras_ok[b])
            begin
               ras_cnt_q[b] <= ras_cnt_q[b] + 4'h1;
            end
         end
      end
   end

   assign bank_active = bank_active_q;

   // Misuse is refused and flagged for one cycle
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         illegal_cmd <= 1'b0;
      else
         illegal_cmd <= ((cmd_rd || cmd_wr) && !col_ok) ||
            (cmd_bst && !full_page) ||
            (cmd_act && col_ok);
   end

   // ----------------------------------------
   // Array port
   // ----------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         mem_rd_en <= 1'b0;
         mem_wr_en <= 1'b0;
         mem_bank <= 2'h0;
         mem_row <= 13'h0000;
         mem_col <= 9'h000;
         mem_wdata <= 16'h0000;
         mem_wbe <= 2'h0;
      end
      else
      begin
         mem_rd_en <= rd_issue;
         mem_wr_en <= wr_issue;
         mem_bank <= issue_bank;
         mem_row <= row_q[issue_bank];
         mem_col <= gen_col;
         mem_wdata <= dq_in;
         // Write mask acts in the cycle it is sampled
         mem_wbe <= ~dqm;
      end
   end

   // ----------------------------------------
   // Read return path
   // ----------------------------------------
   logic rv_q;
   scbp_data_t rpipe_q;
   logic [1:0] dqm_d_q;
   logic src_v;
   scbp_data_t src_d;

   // Latency one is not offered; anything but three runs as two
   assign src_v = cl3 ? rv_q : mem_rd_en;
   assign src_d = cl3 ? rpipe_q : mem_rdata;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rv_q <= 1'b0;
         rpipe_q <= 16'h0000;
         dqm_d_q <= 2'h0;
         dq_out <= 16'h0000;
         dq_oe <= 2'h0;
      end
      else
      begin
         rv_q <= mem_rd_en;
         rpipe_q <= mem_rdata;
         dqm_d_q <= dqm;
         dq_out <= src_d;
         dq_oe <= {2{src_v}} & ~dqm_d_q;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_rd_cl3;
      rd_go && cl3 ##1 dqm == 2'h0 && cl3 ##1 cl3;
   endsequence

   sequence s_stop_cl3;
      bst_go && cl3 ##1 !rd_go && cl3 ##1 !rd_go && cl3;
   endsequence

   sequence s_seq4;
      rd_go && mode_burst_len == `SCBP_BL4 && !mode_interleave
      ##1 rd_issue && !rd_go && mode_burst_len == `SCBP_BL4 &&
      !mode_interleave;
   endsequence

   sequence s_il8;
      rd_go && mode_burst_len == `SCBP_BL8 && mode_interleave
      ##1 rd_issue && !rd_go && mode_burst_len == `SCBP_BL8 &&
      mode_interleave;
   endsequence

   property p_rd_start;
      @(posedge ref_clk) disable iff (reset)
      rd_go |=> mem_rd_en && mem_col == $past(addr[8:0]);
   endproperty
   a_rd_start: assert property (p_rd_start)
      else $error("read did not start at the given column");

   property p_wr_start;
      @(posedge ref_clk) disable iff (reset)
      wr_go && dqm == 2'h0 |=> mem_wr_en && mem_wbe == 2'h3 &&
         mem_wdata == $past(dq_in) && mem_col == $past(addr[8:0]);
   endproperty
   a_wr_start: assert property (p_wr_start)
      else $error("first write word not taken with the command");

   property p_every_cycle;
      @(posedge ref_clk) disable iff (reset)
      new_cmd ##1 new_cmd |=> mem_rd_en || mem_wr_en;
   endproperty
   a_every_cycle: assert property (p_every_cycle)
      else $error("back to back column command was lost");

   property p_rd_latency;
      @(posedge ref_clk) disable iff (reset)
      s_rd_cl3 |=> dq_oe == 2'h3 && dq_out == $past(mem_rdata, 2);
   endproperty
   a_rd_latency: assert property (p_rd_latency)
      else $error("read data not driven at latency three");

   property p_dqm_float;
      @(posedge ref_clk) disable iff (reset)
      dqm == 2'h3 |-> ##2 dq_oe == 2'h0;
   endproperty
   a_dqm_float: assert property (p_dqm_float)
      else $error("mask did not float output two cycles later");

   property p_wr_mask;
      @(posedge ref_clk) disable iff (reset)
      wr_issue && dqm == 2'h3 |=> mem_wr_en && mem_wbe == 2'h0;
   endproperty
   a_wr_mask: assert property (p_wr_mask)
      else $error("masked write word reached the array");

   property p_stop_float;
      @(posedge ref_clk) disable iff (reset)
      s_stop_cl3 |=> dq_oe == 2'h0;
   endproperty
   a_stop_float: assert property (p_stop_float)
      else $error("output still driven latency after burst stop");

   property p_stop_open;
      @(posedge ref_clk) disable iff (reset)
      bst_go && !ap_fire |=> !mem_rd_en && !mem_wr_en &&
         bank_active == $past(bank_active_q);
   endproperty
   a_stop_open: assert property (p_stop_open)
      else $error("burst stop did not end burst or closed a row");

   property p_seq_wrap;
      @(posedge ref_clk) disable iff (reset)
      s_seq4 |=> mem_col[8:2] == $past(addr[8:2], 2) &&
         mem_col[1:0] == $past(addr[1:0], 2) + 2'h1;
   endproperty
   a_seq_wrap: assert property (p_seq_wrap)
      else $error("sequential second column wrong");

   property p_interleave;
      @(posedge ref_clk) disable iff (reset)
      s_il8 |=> mem_col == ($past(addr[8:0], 2) ^ 9'h001);
   endproperty
   a_interleave: assert property (p_interleave)
      else $error("interleave second column wrong");

   property p_rd_ends_wr;
      @(posedge ref_clk) disable iff (reset)
      state_q == SCBP_WRITE && rd_go |=> mem_rd_en && !mem_wr_en;
   endproperty
   a_rd_ends_wr: assert property (p_rd_ends_wr)
      else $error("write continued after a read");

   property p_pre_all;
      @(posedge ref_clk) disable iff (reset)
      cmd_pre && addr[`SCBP_AP_BIT] |=> bank_active == 4'h0;
   endproperty
   a_pre_all: assert property (p_pre_all)
      else $error("precharge all left a bank open");

   property p_pre_one;
      @(posedge ref_clk) disable iff (reset)
      cmd_pre && !addr[`SCBP_AP_BIT] |=>
         !bank_active[$past(bank_select)];
   endproperty
   a_pre_one: assert property (p_pre_one)
      else $error("single bank precharge left the bank open");

   property p_idle_reject;
      @(posedge ref_clk) disable iff (reset)
      (cmd_rd || cmd_wr) && !col_ok |=>
         !mem_rd_en && !mem_wr_en && illegal_cmd;
   endproperty
   a_idle_reject: assert property (p_idle_reject)
      else $error("column command to idle bank was accepted");

   property p_wr_ap;
      @(posedge ref_clk) disable iff (reset)
      burst_end_ap && !end_is_rd |=> !ap_fire ##1
         (ap_fire || !ras_ok[ap_bank_q]);
   endproperty
   a_wr_ap: assert property (p_wr_ap)
      else $error("write auto precharge not two clocks after last word");

   property p_rd_ap;
      @(posedge ref_clk) disable iff (reset)
      burst_end_ap && end_is_rd && ras_ok[issue_bank] |=> ap_fire;
   endproperty
   a_rd_ap: assert property (p_rd_ap)
      else $error("read auto precharge did not start");

endmodule // scbp_column_engine

`default_nettype wire

// ---- tb/scbp_array_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module scbp_array_model (
   // Clock
   input wire logic ref_clk,
   // Array port
   input wire logic mem_rd_en,
   input wire logic mem_wr_en,
   input wire scbp_pkg::scbp_bank_t mem_bank,
   input wire scbp_pkg::scbp_col_t mem_col,
   input wire scbp_pkg::scbp_data_t mem_wdata,
   input wire logic [1:0] mem_wbe,
   output scbp_pkg::scbp_data_t mem_rdata
);
   import scbp_pkg::*;

   // -------------------------------
   // Storage, one row per bank
   // -------------------------------
   scbp_data_t arr [0:2047];
   logic [10:0] a;

   assign a = {mem_bank, mem_col};

   initial
   begin
      for (int i = 0; i < 2048; i++)
         arr[i] = 16'h3C00 ^ 16'(i);
   end

   // Byte enables come from the mask pins
   always @(posedge ref_clk)
   begin
      if (mem_wr_en && mem_wbe[0])
         arr[a][7:0] <= mem_wdata[7:0];
      if (mem_wr_en && mem_wbe[1])
         arr[a][15:8] <= mem_wdata[15:8];
   end

   // Idle cycles show the inverse so stale data cannot match
   assign mem_rdata = mem_rd_en ? arr[a] : ~arr[a];

endmodule // scbp_array_model

`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import scbp_pkg::*;

   // -------------------------------
   // Commands and signals
   // -------------------------------
   localparam logic [3:0] NOP = 4'h7;
   localparam logic [3:0] ACT = 4'h3;
   localparam logic [3:0] RD = 4'h5;
   localparam logic [3:0] WR = 4'h4;
   localparam logic [3:0] PRE = 4'h2;
   localparam logic [3:0] BST = 4'h6;
   // One row per bank keeps the array model flat
   localparam scbp_row_t ROW = 13'h0005;

   logic ref_clk, reset, cs_n, ras_n, cas_n, we_n;
   logic mode_interleave, mem_rd_en, mem_wr_en, illegal_cmd;
   logic [1:0] dqm, dq_oe, mem_wbe, mode_cas_lat;
   logic [2:0] mode_burst_len;
   logic [3:0] bank_active;
   scbp_bank_t bank_select, mem_bank;
   scbp_row_t addr, mem_row;
   scbp_col_t mem_col;
   scbp_data_t dq_in, dq_out, mem_wdata, mem_rdata, wseq;
   scbp_data_t exp_mem [0:2047];
   int err_total, n_tests, bl;

   scbp_column_engine u_dut (
      .ref_clk(ref_clk), .reset(reset), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select),
      .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe), .mode_burst_len(mode_burst_len),
      .mode_interleave(mode_interleave), .mode_cas_lat(mode_cas_lat),
      .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_bank(mem_bank),
      .mem_row(mem_row), .mem_col(mem_col), .mem_wdata(mem_wdata),
      .mem_wbe(mem_wbe), .mem_rdata(mem_rdata),
      .bank_active(bank_active), .illegal_cmd(illegal_cmd)
   );

   scbp_array_model u_array (
      .ref_clk(ref_clk), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
      .mem_bank(mem_bank), .mem_col(mem_col), .mem_wdata(mem_wdata),
      .mem_wbe(mem_wbe), .mem_rdata(mem_rdata)
   );

   always #10 ref_clk = ~ref_clk;

   // -------------------------------
   // Tasks
   // -------------------------------
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge ref_clk);
         #1;
      end
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   task automatic summarize;
      if (err_total == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic mode(input int l, input logic il, input logic [1:0] c);
      bl = l;
      mode_interleave = il;
      mode_cas_lat = c;
      mode_burst_len = (l == 512) ? 3'h7 : 3'($clog2(l));
   endtask

   function automatic scbp_col_t ecol(scbp_col_t base, int k);
      scbp_col_t m;
      m = scbp_col_t'(bl - 1);
      if (mode_interleave && bl != 512)
         return base ^ scbp_col_t'(k);
      return (base & ~m) | ((base + scbp_col_t'(k)) & m);
   endfunction

   task automatic iss(input logic [3:0] c, input scbp_bank_t b,
                      input scbp_row_t a, input logic [1:0] m);
      {cs_n, ras_n, cas_n, we_n} = c;
      bank_select = b;
      addr = a;
      dqm = m;
      tick(1);
   endtask

   // Releases the command pins; the caller owns that time step
   task automatic nop_cmd;
      {cs_n, ras_n, cas_n, we_n} = NOP;
      dqm = 2'h0;
   endtask

   // Checks n words; when not full, returns in cycle n for an interrupt
   task automatic run(input logic [3:0] c, input scbp_bank_t b,
                      input scbp_col_t col, input logic ap, input int n,
                      input logic full, input logic [31:0] mk);
      int cl, last, k;
      logic rd;
      logic [1:0] oe;
      scbp_col_t e;
      scbp_data_t mb;
      rd = (c == RD);
      cl = (mode_cas_lat == 2'h3) ? 3 : 2;
      last = !full ? n : rd ? n + cl : n + 1;
      if (!rd)
         dq_in = wseq;
      iss(c, b, {2'h0, ap, 1'b0, col}, mk[1:0]);
      for (int i = 1; i <= last; i++)
      begin
         if (i <= n)
         begin
            e = ecol(col, i - 1);
            chk("mem_col", 16'(e), 16'(mem_col));
            chk("mem_bank", 16'(b), 16'(mem_bank));
            chk("mem_row", 16'(ROW), 16'(mem_row));
            chk("illegal_cmd", 16'h0, 16'(illegal_cmd));
            chk("mem_rd_en", 16'(rd), 16'(mem_rd_en));
            chk("mem_wr_en", 16'(!rd), 16'(mem_wr_en));
            if (!rd)
            begin
               oe = ~mk[2*(i-1) +: 2];
               mb = {{8{oe[1]}}, {8{oe[0]}}};
               chk("mem_wbe", 16'(oe), 16'(mem_wbe));
               chk("mem_wdata", wseq, mem_wdata);
               chk("dq_oe", 16'h0, 16'(dq_oe));
               exp_mem[{b, e}] = (exp_mem[{b, e}] & ~mb) | (wseq & mb);
               wseq++;
               if (i < n)
                  dq_in = wseq;
            end
         end
         else if (i == n + 1)
            chk("mem_en", 16'h0, 16'({mem_rd_en, mem_wr_en}));
         if (rd && i >= cl)
         begin
            k = i - cl;
            oe = (k < n) ? ~mk[2*(i-2) +: 2] : 2'h0;
            mb = {{8{oe[1]}}, {8{oe[0]}}};
            chk("dq_oe", 16'(oe), 16'(dq_oe));
            if (k < n)
               chk("dq_out", exp_mem[{b, ecol(col, k)}] & mb,
                   dq_out & mb);
         end
         if (ap && rd && i >= n)
            chk("ap_read", 16'(i == n), 16'(bank_active[b]));
         if (i < last)
         begin
            {cs_n, ras_n, cas_n, we_n} = NOP;
            dqm = (i < n) ? mk[2*i +: 2] : 2'h0;
            tick(1);
         end
      end
      if (ap && !rd)
      begin
         chk("ap_write", 16'h1, 16'(bank_active[b]));
         tick(1);
         chk("ap_write", 16'h0, 16'(bank_active[b]));
      end
      if (!rd && full)
         dq_in = ~wseq; // Released bus shows the inverse
   endtask

   // -------------------------------
   // Scenarios
   // -------------------------------
   initial
   begin
      int lens [4];
      lens = '{1, 2, 4, 8};
      ref_clk = 1'b0;
      reset = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = NOP;
      bank_select = 2'h0;
      addr = 13'h0000;
      dqm = 2'h0;
      dq_in = 16'h0000;
      wseq = 16'hA000;
      err_total = 0;
      n_tests = 0;
      mode(4, 1'b0, 2'h2);
      for (int i = 0; i < 2048; i++)
         exp_mem[i] = 16'h3C00 ^ 16'(i);
      repeat (3) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      chk("bank_active", 16'h0, 16'(bank_active));
      chk("dq_oe", 16'h0, 16'(dq_oe));
      for (int b = 0; b < 4; b++)
      begin
         iss(ACT, 2'(b), ROW, 2'h0);
         chk("bank_active", 16'((2 << b) - 1), 16'(bank_active));
      end
      iss(ACT, 2'h2, ROW, 2'h0);
      chk("illegal_cmd", 16'h1, 16'(illegal_cmd));
      nop_cmd;
      tick(2);
      for (int il = 0; il < 2; il++)
         for (int j = 0; j < 4; j++)
         begin
            mode(lens[j], 1'(il), 2'h2);
            run(WR, 2'(j), 9'h0D5, 1'b0, bl, 1'b1, 32'h0);
            run(RD, 2'(j), 9'h0D5, 1'b0, bl, 1'b1, 32'h0);
         end
      mode(4, 1'b0, 2'h2);
      run(WR, 2'h0, 9'h030, 1'b0, 4, 1'b1, 32'h34);
      run(RD, 2'h0, 9'h030, 1'b0, 4, 1'b1, 32'h8);
      run(RD, 2'h0, 9'h040, 1'b0, 2, 1'b0, 32'h0);
      run(RD, 2'h0, 9'h048, 1'b0, 4, 1'b1, 32'h0);
      run(WR, 2'h1, 9'h050, 1'b0, 2, 1'b0, 32'h0);
      run(WR, 2'h1, 9'h058, 1'b0, 4, 1'b1, 32'h0);
      run(RD, 2'h1, 9'h050, 1'b0, 4, 1'b1, 32'h0);
      run(WR, 2'h2, 9'h060, 1'b0, 1, 1'b0, 32'h0);
      run(RD, 2'h2, 9'h060, 1'b0, 4, 1'b1, 32'h0);
      run(RD, 2'h3, 9'h070, 1'b0, 1, 1'b0, 32'h3);
      run(WR, 2'h3, 9'h070, 1'b0, 4, 1'b1, 32'hF);
      mode(512, 1'b0, 2'h3);
      run(RD, 2'h0, 9'h1FE, 1'b0, 4, 1'b0, 32'h0);
      iss(BST, 2'h0, 13'h0000, 2'h0);
      chk("mem_rd_en", 16'h0, 16'(mem_rd_en));
      nop_cmd;
      chk("dq_oe", 16'h3, 16'(dq_oe));
      tick(1);
      chk("dq_oe", 16'h3, 16'(dq_oe));
      tick(1);
      chk("dq_oe", 16'h0, 16'(dq_oe));
      chk("bank_active", 16'hF, 16'(bank_active));
      mode(4, 1'b0, 2'h2); // Auto precharge below page only
      iss(BST, 2'h0, 13'h0000, 2'h0);
      chk("illegal_cmd", 16'h1, 16'(illegal_cmd));
      // Nothing interrupts these bursts
      run(RD, 2'h1, 9'h080, 1'b1, 4, 1'b1, 32'h0);
      run(WR, 2'h2, 9'h090, 1'b1, 4, 1'b1, 32'h0);
      chk("bank_active", 16'h9, 16'(bank_active));
      tick(3);
      iss(ACT, 2'h1, ROW, 2'h0);
      chk("bank_active", 16'hB, 16'(bank_active));
      iss(PRE, 2'h3, 13'h0000, 2'h0);
      chk("bank_active", 16'h3, 16'(bank_active));
      iss(PRE, 2'h2, 13'h0400, 2'h0);
      chk("bank_active", 16'h0, 16'(bank_active));
      iss(RD, 2'h0, 13'h0000, 2'h0);
      chk("illegal_cmd", 16'h1, 16'(illegal_cmd));
      chk("mem_rd_en", 16'h0, 16'(mem_rd_en));
      nop_cmd;
      tick(2);
      summarize;
   end

   // Hang guard
   initial
   begin
      #200000;
      err_total++;
      summarize;
   end

endmodule // tb_top

`default_nettype wire
